// >>> bench/i2c_master_model.sv
// two-wire bus master standing in for the host controller
// assumes sda has a pull-up; the bench resolves the wire from both drivers
`timescale 1ns/1ps

module i2c_master_model (
	output logic scl,
	output logic sda_drv,
	input wire logic sda_wire
);
	// idle high; clock only inside frames
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// one pulse; data moves only while scl is low
	task automatic pulse(input logic b, output logic s);
		#12 sda_drv = b;
		#12 scl = 1'b1;
		#12 s = sda_wire;
		#12 scl = 1'b0;
	endtask : pulse
	// start or repeated start
	task automatic start();
		#12 sda_drv = 1'b1;
		#12 scl = 1'b1;
		#12 sda_drv = 1'b0;
		#12 scl = 1'b0;
	endtask : start
	// stop
	task automatic stop();
		#12 sda_drv = 1'b0;
		#12 scl = 1'b1;
		#12 sda_drv = 1'b1;
	endtask : stop
	// msb first, then the ack slot
	task automatic send(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(d[i], s);
		pulse(1'b1, s);
		ack = !s;
	endtask : send
	// last byte left unacknowledged
	task automatic recv(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b1, s);
			d[i] = s;
		end
		pulse(!more, s);
	endtask : recv
endmodule : i2c_master_model

// >>> bench/i2c_port_properties.sv
// bus-level checks on the serial register port
// assumes scl stands high between frames and sda has a pull-up
`timescale 1ns/1ps
`include "i2c_port_consts.svh"

module i2c_port_properties #(
	parameter logic [7:0] ID_VALUE = `ID_VALUE_DEFAULT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_clk,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic addr_strap_bit_hi,
	input wire logic addr_strap_bit_lo,
	input wire i2c_port_pkg::cfg_t cfg_regs
);
	import i2c_port_pkg::*;
	logic start_tog = 1'b0;
	logic seen_reg;
	logic first_reg;
	logic sel_reg;
	logic rd_reg;
	logic oe_rise_reg;
	logic [3:0] cnt_reg;
	logic [6:0] sh_reg;
	wire live = seen_reg == start_tog;
	wire match = sh_reg == {`ADDR_UPPER, addr_strap_bit_hi, addr_strap_bit_lo};
	wire last_bit = live && cnt_reg == 4'h7;
	wire ack_slot = live && cnt_reg == 4'h8;
	always @(negedge sda_in) begin
		if (scl_clk) start_tog <= ~start_tog;
	end
	always_ff @(posedge scl_clk) begin
		seen_reg <= start_tog;
		sh_reg <= {sh_reg[5:0], sda_in};
		oe_rise_reg <= sda_oe;
		if (rst || !live) begin
			cnt_reg <= {3'h0, !rst};
			first_reg <= !rst;
			sel_reg <= 1'b0;
			rd_reg <= 1'b0;
		end else begin
			cnt_reg <= ack_slot ? 4'h0 : cnt_reg + 4'h1;
			if (ack_slot) first_reg <= 1'b0;
			if (first_reg && last_bit) sel_reg <= match;
			if (first_reg && last_bit) rd_reg <= match && sda_in;
		end
	end
	sequence s_own_addr;
		first_reg && last_bit && match;
	endsequence
	sequence s_other_addr;
		first_reg && last_bit && !match;
	endsequence
	a_own_addr_ack: assert property (@(posedge scl_clk) disable iff (rst)
		s_own_addr |=> sda_oe) else $error("own address not acknowledged");
	a_other_addr_quiet: assert property (@(posedge scl_clk) disable iff (rst)
		s_other_addr |=> !sda_oe [*8]) else $error("foreign address answered");
	a_data_byte_ack: assert property (@(posedge scl_clk) disable iff (rst)
		last_bit && !first_reg && sel_reg && !rd_reg |=> sda_oe) else $error("byte not acked");
	a_ack_released: assert property (@(posedge scl_clk) disable iff (rst)
		ack_slot && sel_reg && !rd_reg |=> !sda_oe) else $error("ack held too long");
	a_read_slot_free: assert property (@(posedge scl_clk) disable iff (rst)
		ack_slot && rd_reg && !first_reg |-> !sda_oe) else $error("master ack slot driven");
	a_oe_still_high: assert property (@(negedge scl_clk) disable iff (rst)
		sda_oe == oe_rise_reg) else $error("sda moved while scl high");
	a_pull_low_only: assert property (@(posedge clk) disable iff (rst)
		sda_oe |-> !sda_out) else $error("sda driven high");
	a_id_byte_fixed: assert property (@(posedge clk) disable iff (rst)
		cfg_regs[7:0] == ID_VALUE) else $error("identity byte changed");
endmodule : i2c_port_properties

bind i2c_slave_register_port i2c_port_properties #(.ID_VALUE(ID_VALUE)) i_props (.clk, .rst,
	.scl_clk, .sda_in, .sda_out, .sda_oe, .addr_strap_bit_hi, .addr_strap_bit_lo, .cfg_regs);

// >>> bench/tb_top.sv
// self-checking bench for the serial register port
// assumes the master model drives scl and the wire has a pull-up
`timescale 1ns/1ps
`include "i2c_port_consts.svh"

module tb_top;
	import i2c_port_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic strap_hi = 1'b0;
	logic strap_lo = 1'b0;
	logic scl;
	logic sda_drv;
	logic sda_out;
	logic sda_oe;
	wire sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);
	cfg_t cfg;
	byte_t exp [0:11];
	int failures = 0;
	int checks_done = 0;
	always #20 clk = ~clk;
	i2c_master_model i_master (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));
	i2c_slave_register_port i_i2c_slave_register_port (.clk(clk), .rst(rst), .scl_clk(scl),
		.sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit_hi(strap_hi),
		.addr_strap_bit_lo(strap_lo), .cfg_regs(cfg));
	task automatic complete_run();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
		checks_done++;
		if (got !== want) begin
			failures++;
			$display("FAIL %0t %s got %h want %h", $time, what, got, want);
		end
	endtask : check
	task automatic load_defaults();
		for (int i = 1; i < 11; i++) exp[i] = 8'(88'(`CFG_DEFAULTS) >> (8 * i));
		exp[0] = `ID_VALUE_DEFAULT;
		exp[11] = 8'h00;
	endtask : load_defaults
	task automatic check_bank();
		for (int i = 0; i < 11; i++) check(cfg[8 * i +: 8], exp[i], "bank");
	endtask : check_bank
	task automatic flush();
		repeat (3) begin
			i_master.start();
			i_master.stop();
		end
	endtask : flush
	task automatic put(input logic [6:0] a, input byte_t p, input byte_t d[$], input logic w);
		logic ack;
		i_master.start();
		i_master.send({a, 1'b0}, ack);
		check({7'h0, ack}, {7'h0, w}, "addr ack");
		i_master.send(p, ack);
		check({7'h0, ack}, {7'h0, w}, "ptr ack");
		foreach (d[i]) begin
			i_master.send(d[i], ack);
			check({7'h0, ack}, {7'h0, w}, "data ack");
		end
		i_master.stop();
		repeat (8) @(negedge clk);
	endtask : put
	task automatic get(input logic [6:0] a, input byte_t p, input int n, input logic sr);
		logic ack;
		byte_t d;
		i_master.start();
		i_master.send({a, 1'b0}, ack);
		i_master.send(p, ack);
		if (!sr) i_master.stop();
		i_master.start();
		i_master.send({a, 1'b1}, ack);
		check({7'h0, ack}, 8'h01, "read addr ack");
		for (int i = 0; i < n; i++) begin
			i_master.recv(i < n - 1, d);
			check(d, exp[p + i], "read data");
		end
		i_master.stop();
	endtask : get
	// each strap answers its own address; bursts land in successive registers
	task automatic t_straps();
		for (int s = 0; s < 4; s++) begin
			@(negedge clk);
			{strap_hi, strap_lo} = 2'(s);
			repeat (6) @(negedge clk);
			exp[2 * s + 1] = 8'h90 + 8'(s);
			exp[2 * s + 2] = 8'ha0 + 8'(s);
			put(7'h58 + 7'(s), 8'(2 * s + 1), '{exp[2 * s + 1], exp[2 * s + 2]}, 1'b1);
			check_bank();
		end
	endtask : t_straps
	// another address is ignored for the whole transfer
	task automatic t_foreign();
		put(7'h58, 8'h09, '{8'h55, 8'h66}, 1'b0);
		check_bank();
	endtask : t_foreign
	// read after repeated start and after stop plus start, into the reserved range
	task automatic t_reads();
		get(7'h5b, 8'h01, 4, 1'b1);
		get(7'h5b, 8'h0a, 2, 1'b0);
	endtask : t_reads
	// the restore code at the identity location brings back all defaults
	task automatic t_restore();
		put(7'h5b, 8'h00, '{8'haa}, 1'b1);
		load_defaults();
		check_bank();
	endtask : t_restore
	// watchdog sized well above the roughly 20 us the scenarios need
	initial begin
		#400000;
		failures++;
		$display("FAIL %0t watchdog expired", $time);
		complete_run();
	end
	initial begin
		load_defaults();
		fork
			flush();
			repeat (6) @(negedge clk);
		join
		@(negedge clk);
		rst = 1'b0;
		flush();
		check_bank();
		t_straps();
		t_foreign();
		t_reads();
		t_restore();
		complete_run();
	end
endmodule : tb_top

// >>> include/i2c_port_consts.svh
// constants of the two-wire register port: address, register map, bit counts
// assumes inclusion by bare name from the package and the design modules
`ifndef I2C_PORT_CONSTS_SVH
`define I2C_PORT_CONSTS_SVH

`define ADDR_UPPER 5'h16
`define REG_COUNT 11
`define REG_LAST 8'h0a
`define ID_ADDR 8'h00
`define ID_VALUE_DEFAULT 8'h3c
`define SOFT_RST_CODE 8'haa
`define CFG_DEFAULTS 88'h4a08034e431011e8097000
`define BYTE_BITS 8
`define ACK_SLOT 4'h8
`define BIT_FIRST 4'h1
`define BIT_ZERO 4'h0
`define BYTE_ZERO 8'h00
`define PTR_STEP 8'h01

`endif

// >>> include/i2c_port_pkg.sv
// types shared by the two-wire register port and its register bank
// assumes the constants header is on the include path
`include "i2c_port_consts.svh"

package i2c_port_pkg;
	typedef logic [`BYTE_BITS-1:0] byte_t;
	typedef logic [`REG_COUNT*`BYTE_BITS-1:0] cfg_t;
	typedef logic [1:0] strap_t;
	typedef logic [3:0] bitcnt_t;
	// gray codes along idle, address, pointer, write data; read data one step from address
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_PTR = 3'h3,
		ST_WDATA = 3'h2,
		ST_RDATA = 3'h5
	} link_state_e;
endpackage : i2c_port_pkg

// >>> include/reg_port_if.sv
// carrier between the serial port and the configuration register bank
// assumes the package is compiled first; all signals live in the clk domain
`timescale 1ns/1ps
`include "i2c_port_consts.svh"

interface reg_port_if;
	import i2c_port_pkg::*;
	logic wr_en;
	byte_t wr_addr;
	byte_t wr_data;
	byte_t regs [`REG_COUNT];
	modport bank (
		input wr_en,
		input wr_addr,
		input wr_data,
		output regs
	);
	modport port (
		output wr_en,
		output wr_addr,
		output wr_data,
		input regs
	);
endinterface : reg_port_if

// >>> verilog/config_reg_bank.sv
// configuration register bank: defaults, byte writes, identity word, soft reset
// assumes one write strobe per clk from the serial port, clk domain only
`timescale 1ns/1ps
`include "i2c_port_consts.svh"

module config_reg_bank #(
	parameter logic [7:0] ID_VALUE = `ID_VALUE_DEFAULT // arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	reg_port_if.bank bus
);
	import i2c_port_pkg::*;

	localparam cfg_t DEFAULTS = `CFG_DEFAULTS;

	wire logic soft_rst;
	wire logic id_hit;

	assign id_hit = bus.wr_en && (bus.wr_addr == `ID_ADDR);
	// identity location written with the magic code restores all defaults
	assign soft_rst = id_hit && (bus.wr_data == `SOFT_RST_CODE);

	// identity word is read only
	assign bus.regs[0] = ID_VALUE;

	genvar i;
	generate
		for (i = 1; i < `REG_COUNT; i++) begin : g_reg
			byte_t cell_reg;
			wire logic hit;
			assign hit = bus.wr_en && (bus.wr_addr == 8'(i));
			always_ff @(posedge clk) begin
				if (rst || soft_rst) begin
					cell_reg <= DEFAULTS[i*`BYTE_BITS +: `BYTE_BITS];
				end else if (hit) begin
					cell_reg <= bus.wr_data;
				end
			end
			assign bus.regs[i] = cell_reg;
		end
	endgenerate
endmodule : config_reg_bank

// >>> verilog/i2c_slave_register_port.sv
// two-wire slave port reaching the configuration register bank
// assumes scl_clk is the bus clock pin used as a clock, sda is open drain
// with external pull-up, straps are static pins, rst is held while scl runs
`timescale 1ns/1ps
`include "i2c_port_consts.svh"

module i2c_slave_register_port #(
	parameter logic [7:0] ID_VALUE = `ID_VALUE_DEFAULT // arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_clk,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_strap_bit_hi,
	input wire logic addr_strap_bit_lo,
	output i2c_port_pkg::cfg_t cfg_regs
);
	import i2c_port_pkg::*;

	reg_port_if bus ();

	config_reg_bank #(
		.ID_VALUE(ID_VALUE)
	) u_bank (
		.clk(clk),
		.rst(rst),
		.bus(bus)
	);

	// ---------------- clk domain ----------------

	strap_t strap_s1_reg;
	strap_t strap_s2_reg;
	strap_t strap_s3_reg;
	strap_t strap_reg;
	wire logic strap_agree;

	// strap pins pass three flops, accepted once the last two agree
	assign strap_agree = (strap_s2_reg == strap_s3_reg);

	always_ff @(posedge clk) begin
		if (rst) begin
			strap_s1_reg <= 2'h0;
			strap_s2_reg <= 2'h0;
			strap_s3_reg <= 2'h0;
		end else begin
			strap_s1_reg <= {addr_strap_bit_hi, addr_strap_bit_lo};
			strap_s2_reg <= strap_s1_reg;
			strap_s3_reg <= strap_s2_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			strap_reg <= 2'h0;
		end else if (strap_agree) begin
			strap_reg <= strap_s3_reg;
		end
	end

	// write events arrive as a toggle from the link domain
	logic wr_tgl_reg;
	byte_t wr_addr_reg;
	byte_t wr_data_reg;
	logic wtg_s1_reg;
	logic wtg_s2_reg;
	logic wtg_s3_reg;
	logic bank_wr_reg;
	byte_t bank_addr_reg;
	byte_t bank_data_reg;
	logic sda_out_reg;
	wire logic wr_event;

	assign wr_event = wtg_s2_reg ^ wtg_s3_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			wtg_s1_reg <= 1'b0;
			wtg_s2_reg <= 1'b0;
			wtg_s3_reg <= 1'b0;
		end else begin
			wtg_s1_reg <= wr_tgl_reg;
			wtg_s2_reg <= wtg_s1_reg;
			wtg_s3_reg <= wtg_s2_reg;
		end
	end

	// address and data stay still for a whole byte time after the toggle
	always_ff @(posedge clk) begin
		if (rst) begin
			bank_wr_reg <= 1'b0;
			bank_addr_reg <= `BYTE_ZERO;
			bank_data_reg <= `BYTE_ZERO;
		end else begin
			bank_wr_reg <= wr_event;
			bank_addr_reg <= wr_addr_reg;
			bank_data_reg <= wr_data_reg;
		end
	end

	assign bus.wr_en = bank_wr_reg;
	assign bus.wr_addr = bank_addr_reg;
	assign bus.wr_data = bank_data_reg;

	// the pin only ever pulls low
	always_ff @(posedge clk) begin
		if (rst) begin
			sda_out_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0;
		end
	end

	assign sda_out = sda_out_reg;

	genvar gi;
	generate
		for (gi = 0; gi < `REG_COUNT; gi++) begin : g_cfg
			assign cfg_regs[gi*`BYTE_BITS +: `BYTE_BITS] = bus.regs[gi];
		end
	endgenerate

	// ---------------- link domain (scl) ----------------

	logic lrst_s1_reg;
	logic lrst_s2_reg;
	strap_t lstrap_s1_reg;
	strap_t lstrap_s2_reg;
	wire logic link_rst;

	assign link_rst = lrst_s2_reg;

	always_ff @(posedge scl_clk) begin
		lrst_s1_reg <= rst;
		lrst_s2_reg <= lrst_s1_reg;
	end

	always_ff @(posedge scl_clk) begin
		if (link_rst) begin
			lstrap_s1_reg <= 2'h0;
			lstrap_s2_reg <= 2'h0;
		end else begin
			lstrap_s1_reg <= strap_reg;
			lstrap_s2_reg <= lstrap_s1_reg;
		end
	end

	// start and stop are sda edges while scl is high
	logic start_tgl_reg;
	logic stop_tgl_reg;

	always_ff @(negedge sda_in) begin
		if (link_rst) begin
			start_tgl_reg <= 1'b0;
		end else if (scl_clk) begin
			start_tgl_reg <= ~start_tgl_reg;
		end
	end

	always_ff @(posedge sda_in) begin
		if (link_rst) begin
			stop_tgl_reg <= 1'b0;
		end else if (scl_clk) begin
			stop_tgl_reg <= ~stop_tgl_reg;
		end
	end

	link_state_e state_reg;
	link_state_e state_next;
	bitcnt_t bit_cnt_reg;
	byte_t shift_reg;
	byte_t ptr_reg;
	byte_t ptr_next;
	logic start_ack_reg;
	logic stop_ack_reg;
	logic oe_reg;
	byte_t tx_reg;

	wire logic start_pend;
	wire logic stop_pend;
	wire logic ack_slot;
	wire logic addr_hit;
	wire logic rd_dir;
	wire logic wr_fire;
	wire logic master_ack;
	wire logic give_ack;
	wire logic load_rd;
	wire logic send_bit;
	wire logic in_map;
	wire byte_t rd_byte;

	assign start_pend = start_tgl_reg ^ start_ack_reg;
	assign stop_pend = stop_tgl_reg ^ stop_ack_reg;
	assign ack_slot = (bit_cnt_reg == `ACK_SLOT);
	assign addr_hit = (shift_reg[7:1] == {`ADDR_UPPER, lstrap_s2_reg});
	assign rd_dir = shift_reg[0];
	assign wr_fire = (state_reg == ST_WDATA) && ack_slot;
	assign master_ack = ~sda_in;
	assign give_ack = ack_slot && (((state_reg == ST_ADDR) && addr_hit)
		|| (state_reg == ST_PTR) || (state_reg == ST_WDATA));
	assign load_rd = (state_reg == ST_RDATA) && (bit_cnt_reg == `BIT_ZERO);
	assign send_bit = (state_reg == ST_RDATA) && !load_rd && !ack_slot;
	assign in_map = (ptr_reg <= `REG_LAST);
	// reserved locations read as zero; bank words are quasi-static here
	assign rd_byte = in_map ? bus.regs[ptr_reg[3:0]] : `BYTE_ZERO;

	// pointer steps after every data acknowledge slot, no byte limit
	assign ptr_next = ((state_reg == ST_PTR) && ack_slot) ? shift_reg
		: (ack_slot && ((state_reg == ST_WDATA) || (state_reg == ST_RDATA)))
		? ptr_reg + `PTR_STEP : ptr_reg;

	always_comb begin
		state_next = state_reg;
		if (ack_slot) begin
			case (state_reg)
				ST_ADDR: begin
					if (!addr_hit) begin
						state_next = ST_IDLE;
					end else if (rd_dir) begin
						state_next = ST_RDATA;
					end else begin
						state_next = ST_PTR;
					end
				end
				ST_PTR: begin
					state_next = ST_WDATA;
				end
				ST_RDATA: begin
					state_next = master_ack ? ST_RDATA : ST_IDLE;
				end
				ST_WDATA: begin
					state_next = ST_WDATA;
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	// sampling edge: data is stable while scl is high
	always_ff @(posedge scl_clk) begin
		if (link_rst) begin
			start_ack_reg <= 1'b0;
			stop_ack_reg <= 1'b0;
			state_reg <= ST_IDLE;
			bit_cnt_reg <= `BIT_ZERO;
			shift_reg <= `BYTE_ZERO;
			ptr_reg <= `BYTE_ZERO;
		end else if (start_pend) begin
			start_ack_reg <= start_tgl_reg;
			stop_ack_reg <= stop_tgl_reg;
			state_reg <= ST_ADDR;
			bit_cnt_reg <= `BIT_FIRST;
			shift_reg <= {7'h00, sda_in};
		end else if (stop_pend) begin
			stop_ack_reg <= stop_tgl_reg;
			state_reg <= ST_IDLE;
			bit_cnt_reg <= `BIT_ZERO;
		end else if (state_reg != ST_IDLE) begin
			state_reg <= state_next;
			ptr_reg <= ptr_next;
			bit_cnt_reg <= ack_slot ? `BIT_ZERO : bit_cnt_reg + `BIT_FIRST;
			if (!ack_slot) begin
				shift_reg <= {shift_reg[6:0], sda_in};
			end
		end
	end

	// hand a finished data byte to the clk domain
	always_ff @(posedge scl_clk) begin
		if (link_rst) begin
			wr_tgl_reg <= 1'b0;
			wr_addr_reg <= `BYTE_ZERO;
			wr_data_reg <= `BYTE_ZERO;
		end else if (wr_fire && !start_pend && !stop_pend) begin
			wr_tgl_reg <= ~wr_tgl_reg;
			wr_addr_reg <= ptr_reg;
			wr_data_reg <= shift_reg;
		end
	end

	// driving edge: sda changes only while scl is low
	always_ff @(negedge scl_clk) begin
		if (link_rst) begin
			oe_reg <= 1'b0;
			tx_reg <= `BYTE_ZERO;
		end else if (give_ack) begin
			oe_reg <= 1'b1;
		end else if (load_rd) begin
			oe_reg <= ~rd_byte[7];
			tx_reg <= {rd_byte[6:0], 1'b0};
		end else if (send_bit) begin
			oe_reg <= ~tx_reg[7];
			tx_reg <= {tx_reg[6:0], 1'b0};
		end else begin
			oe_reg <= 1'b0;
		end
	end

	assign sda_oe = oe_reg;
endmodule : i2c_slave_register_port
